/* hw/rlsi_top.sv */
// receive line state indicator: state decode, history and registers
`timescale 1ns/10ps
`default_nettype none
`include "rlsi_consts.svh"

// How it works
// - two consecutive idle pairs give code 001
// - signal detect low gives code 010
// - signal detect is ignored while internal loopback is on
// - stop mode shows 010, idle runs may set the low bit giving 011
// - code 011 is reserved and never entered as a real state
// - eight consecutive halt-quiet pairs give code 100
// - eight consecutive halt pairs give code 101
// - eight consecutive quiet pairs give code 110
// - sixteen noise events give code 111
// - unmet conditions set the unknown bit, code keeps last known state
// - upper four bits of the current state register read zero
// - entering a state sets its history bit to one
// - history bits are never cleared by the hardware
// - summary bit is set while any history bit and its mask are set
// - a start delimiter pair gives code 000
// - a new state replaces the old code bits
// - reset forces the unknown state with the unknown bit set
// - writes to the current state register are dropped and flagged
module rlsi_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire rlsi_pkg::rlsi_bus_req_t bus_req,
    output logic [7:0] rd_data_q,
    input wire rlsi_pkg::rlsi_pair_t pair_in,
    input wire logic signal_present_input,
    output logic [3:0] line_state_q,
    output logic history_a_summary_q,
    output logic irq_q
);
    localparam int unsigned NPAT = 4;
    localparam logic [9:0] PAT [NPAT] = '{
        `RLSI_PAIR_IDLE, `RLSI_PAIR_QUIET, `RLSI_PAIR_HALT,
        `RLSI_PAIR_MASTER
    };
    localparam int unsigned THR [NPAT] = '{
        `RLSI_IDLE_PAIRS, `RLSI_RUN_PAIRS, `RLSI_RUN_PAIRS,
        `RLSI_RUN_PAIRS
    };
    localparam logic [4:0] NOISE_LAST = 5'(`RLSI_NOISE_EVENTS);

    rlsi_pkg::rlsi_ls_t ls_q;
    rlsi_pkg::rlsi_ls_t ls_d;
    logic unk_q;
    logic unk_d;
    logic stop_ls0_q;
    logic [7:0] ctrl_q;
    logic [7:0] hist_q;
    logic [7:0] mask_q;
    logic [7:0] irq_en_q;
    logic wr_reject_q;
    logic [4:0] noise_cnt_q;
    logic sd_sync;
    logic sd_ok;
    logic stop_mode;
    logic [9:0] pair_sym;
    logic [NPAT-1:0] match;
    logic [NPAT-1:0] met;
    logic is_jk;
    logic holds;
    logic noise_met;
    logic entered;
    logic went_unknown;
    logic flush_runs;
    logic [7:0] hist_set;
    logic [7:0] hist_clr;
    logic [7:0] irq_stat;
    logic [7:0] rd_mux;
    logic [2:0] code_now;

    function automatic logic [2:0] ls_code(input rlsi_pkg::rlsi_ls_t s);
        logic [2:0] c;
        c = `RLSI_CODE_ACTIVE;
        case (s)
            rlsi_pkg::LS_ACTIVE: c = `RLSI_CODE_ACTIVE;
            rlsi_pkg::LS_IDLE: c = `RLSI_CODE_IDLE;
            rlsi_pkg::LS_NOSIG: c = `RLSI_CODE_NOSIG;
            rlsi_pkg::LS_MASTER: c = `RLSI_CODE_MASTER;
            rlsi_pkg::LS_HALT: c = `RLSI_CODE_HALT;
            rlsi_pkg::LS_QUIET: c = `RLSI_CODE_QUIET;
            rlsi_pkg::LS_NOISE: c = `RLSI_CODE_NOISE;
            default: c = `RLSI_CODE_RSVD;
        endcase
        return c;
    endfunction : ls_code

    // history a bit for a state; idle and active have no history bit
    function automatic logic [7:0] hist_bit(input rlsi_pkg::rlsi_ls_t s);
        logic [7:0] b;
        b = 8'h00;
        case (s)
            rlsi_pkg::LS_NOSIG: b[`RLSI_HIST_NOSIG] = 1'b1;
            rlsi_pkg::LS_QUIET: b[`RLSI_HIST_QUIET] = 1'b1;
            rlsi_pkg::LS_HALT: b[`RLSI_HIST_HALT] = 1'b1;
            rlsi_pkg::LS_MASTER: b[`RLSI_HIST_MASTER] = 1'b1;
            rlsi_pkg::LS_NOISE: b[`RLSI_HIST_NOISE] = 1'b1;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : hist_bit

    rlsi_sync u_sd_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(signal_present_input),
        .level_q(sd_sync)
    );

    assign pair_sym = {pair_in.first, pair_in.second};
    assign stop_mode = ctrl_q[`RLSI_CTRL_STOP];
    assign sd_ok = ctrl_q[`RLSI_CTRL_LOOPBACK] || sd_sync;
    assign is_jk = pair_in.valid && (pair_sym == `RLSI_PAIR_JK);
    assign noise_met = (noise_cnt_q >= NOISE_LAST);
    // the state is forced to no signal while the link is down or stopped; run counters
    // restart only on link loss, so idle runs can still mark stop mode
    assign flush_runs = !sd_ok || stop_mode;

    genvar g;
    generate
        for (g = 0; g < NPAT; g++) begin : g_run
            rlsi_run_cnt #(
                .PATTERN(PAT[g]),
                .THRESH(THR[g])
            ) u_run (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .pair_valid(pair_in.valid),
                .pair_sym(pair_sym),
                .flush(!sd_ok),
                .match(match[g]),
                .met(met[g])
            );
        end
    endgenerate

    // does the current pair keep the present state alive
    always_comb begin
        holds = 1'b0;
        case (ls_q)
            rlsi_pkg::LS_ACTIVE: holds = ~|match;
            rlsi_pkg::LS_IDLE: holds = match[0];
            rlsi_pkg::LS_QUIET: holds = match[1];
            rlsi_pkg::LS_HALT: holds = match[2];
            rlsi_pkg::LS_MASTER: holds = match[3];
            rlsi_pkg::LS_NOISE: holds = pair_in.noise;
            default: holds = 1'b0;
        endcase
    end

    // line state decision, highest priority first
    always_comb begin
        ls_d = ls_q;
        unk_d = unk_q;
        if (flush_runs) begin
            ls_d = rlsi_pkg::LS_NOSIG;
            unk_d = 1'b0;
        end else if (noise_met) begin
            ls_d = rlsi_pkg::LS_NOISE;
            unk_d = 1'b0;
        end else if (pair_in.valid) begin
            if (is_jk) begin
                ls_d = rlsi_pkg::LS_ACTIVE;
                unk_d = 1'b0;
            end else if (met[0]) begin
                ls_d = rlsi_pkg::LS_IDLE;
                unk_d = 1'b0;
            end else if (met[3]) begin
                ls_d = rlsi_pkg::LS_MASTER;
                unk_d = 1'b0;
            end else if (met[2]) begin
                ls_d = rlsi_pkg::LS_HALT;
                unk_d = 1'b0;
            end else if (met[1]) begin
                ls_d = rlsi_pkg::LS_QUIET;
                unk_d = 1'b0;
            end else if (!holds) begin
                unk_d = 1'b1;
            end
        end
    end

    assign entered = (ls_d != ls_q) || (unk_q && !unk_d);
    assign went_unknown = !unk_q && unk_d;

    // the code register never holds the reserved value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls_q <= rlsi_pkg::LS_ACTIVE;
            unk_q <= 1'b1;
        end else begin
            ls_q <= ls_d;
            unk_q <= unk_d;
        end
    end

    // stop mode may still see idle runs; they only touch the low code bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_ls0_q <= 1'b0;
        end else if (!stop_mode) begin
            stop_ls0_q <= 1'b0;
        end else if (met[0]) begin
            stop_ls0_q <= 1'b1;
        end
    end

    // noise events since the last recognised state; held clear while the
    // noise state stands, or a full count would pin that state for good
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            noise_cnt_q <= 5'h00;
        end else if (flush_runs || entered
                     || (ls_q == rlsi_pkg::LS_NOISE && !unk_q)) begin
            noise_cnt_q <= 5'h00;
        end else if (pair_in.noise && !noise_met) begin
            noise_cnt_q <= noise_cnt_q + 5'h01;
        end
    end

    always_comb begin
        hist_set = 8'h00;
        if (entered) begin
            hist_set = hist_bit(ls_d);
            hist_set[`RLSI_HIST_CHANGE] = 1'b1;
        end
        if (went_unknown && ls_q != rlsi_pkg::LS_ACTIVE
            && ls_q != rlsi_pkg::LS_IDLE) begin
            hist_set[`RLSI_HIST_UNK_INV] = 1'b1;
        end
    end

    assign hist_clr = (bus_req.wr && bus_req.addr == `RLSI_OFS_HIST_A)
        ? bus_req.wdata : 8'h00;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= 8'h00;
        end else begin
            hist_q <= (hist_q & ~hist_clr) | hist_set;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RLSI_RST_CTRL;
            mask_q <= `RLSI_RST_MASK;
            irq_en_q <= `RLSI_RST_IRQ_EN;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `RLSI_OFS_CTRL: ctrl_q <= bus_req.wdata;
                `RLSI_OFS_HIST_A_MASK: mask_q <= bus_req.wdata;
                `RLSI_OFS_IRQ_EN: irq_en_q <= bus_req.wdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // write reject: sticky, cleared by a one in the clear register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reject_q <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `RLSI_OFS_CUR_STATE) begin
            wr_reject_q <= 1'b1;
        end else if (bus_req.wr && bus_req.addr == `RLSI_OFS_IRQ_CLR
                     && bus_req.wdata[`RLSI_IRQ_WR_REJECT]) begin
            wr_reject_q <= 1'b0;
        end
    end

    always_comb begin
        irq_stat = 8'h00;
        irq_stat[`RLSI_IRQ_HIST_A] = |(hist_q & mask_q);
        irq_stat[`RLSI_IRQ_WR_REJECT] = wr_reject_q;
    end

    assign code_now = ls_code(ls_q) | {2'b00, stop_ls0_q};

    always_comb begin
        rd_mux = 8'h00;
        case (bus_req.addr)
            `RLSI_OFS_CTRL: rd_mux = ctrl_q;
            `RLSI_OFS_IRQ_STAT: rd_mux = irq_stat;
            `RLSI_OFS_IRQ_EN: rd_mux = irq_en_q;
            `RLSI_OFS_CUR_STATE: rd_mux = {4'h0, unk_q, code_now};
            `RLSI_OFS_HIST_A: rd_mux = hist_q;
            `RLSI_OFS_HIST_A_MASK: rd_mux = mask_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_state_q <= {1'b1, `RLSI_CODE_ACTIVE};
            history_a_summary_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            line_state_q <= {unk_q, code_now};
            history_a_summary_q <= irq_stat[`RLSI_IRQ_HIST_A];
            irq_q <= |(irq_stat & irq_en_q);
        end
    end
endmodule : rlsi_top
`default_nettype wire

/* pkg/rlsi_consts.svh */
// constants for the receive line state indicator
`ifndef RLSI_CONSTS_SVH
`define RLSI_CONSTS_SVH

// register offsets
`define RLSI_OFS_CTRL 8'h00
`define RLSI_OFS_IRQ_STAT 8'h01
`define RLSI_OFS_IRQ_EN 8'h02
`define RLSI_OFS_IRQ_CLR 8'h03
`define RLSI_OFS_CUR_STATE 8'h08
`define RLSI_OFS_HIST_A 8'h09
`define RLSI_OFS_HIST_A_MASK 8'h0b

// control register fields
`define RLSI_CTRL_LOOPBACK 0
`define RLSI_CTRL_STOP 1

// interrupt status fields
`define RLSI_IRQ_HIST_A 0
`define RLSI_IRQ_WR_REJECT 1

// current state register fields
`define RLSI_CUR_UNKNOWN 3

// history a fields
`define RLSI_HIST_NOSIG 0
`define RLSI_HIST_QUIET 1
`define RLSI_HIST_HALT 2
`define RLSI_HIST_MASTER 3
`define RLSI_HIST_NOISE 4
`define RLSI_HIST_CHANGE 6
`define RLSI_HIST_UNK_INV 7

// line state codes
`define RLSI_CODE_ACTIVE 3'h0
`define RLSI_CODE_IDLE 3'h1
`define RLSI_CODE_NOSIG 3'h2
`define RLSI_CODE_RSVD 3'h3
`define RLSI_CODE_MASTER 3'h4
`define RLSI_CODE_HALT 3'h5
`define RLSI_CODE_QUIET 3'h6
`define RLSI_CODE_NOISE 3'h7

// symbol pair patterns, first symbol in the upper five bits
`define RLSI_PAIR_IDLE 10'h3ff
`define RLSI_PAIR_QUIET 10'h000
`define RLSI_PAIR_HALT 10'h084
`define RLSI_PAIR_MASTER 10'h080
`define RLSI_PAIR_JK 10'h311

// run lengths
`define RLSI_IDLE_PAIRS 2
`define RLSI_RUN_PAIRS 8
`define RLSI_NOISE_EVENTS 16

// reset values
`define RLSI_RST_CTRL 8'h00
`define RLSI_RST_MASK 8'h00
`define RLSI_RST_IRQ_EN 8'h00

`endif

/* pkg/rlsi_pkg.sv */
// types shared by the receive line state indicator
package rlsi_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rlsi_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [4:0] first;
        logic [4:0] second;
        logic noise;
    } rlsi_pair_t;

    typedef enum logic [2:0] {
        LS_ACTIVE,
        LS_IDLE,
        LS_NOSIG,
        LS_RSVD,
        LS_MASTER,
        LS_HALT,
        LS_QUIET,
        LS_NOISE
    } rlsi_ls_t;

endpackage : rlsi_pkg

/* hw/rlsi_sync.sv */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module rlsi_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a change only once two stable stages agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule : rlsi_sync
`default_nettype wire

/* hw/rlsi_run_cnt.sv */
// counts consecutive matching symbol pairs against a threshold
`timescale 1ns/10ps
`default_nettype none
module rlsi_run_cnt #(
    parameter logic [9:0] PATTERN = 10'h000,
    parameter int unsigned THRESH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pair_valid,
    input wire logic [9:0] pair_sym,
    input wire logic flush,
    output logic match,
    output logic met
);
    localparam int unsigned CW = $clog2(THRESH + 1);
    localparam logic [CW-1:0] LAST = CW'(THRESH - 1);
    logic [CW-1:0] cnt_q;

    assign match = pair_valid && (pair_sym == PATTERN);
    // the pair in flight completes the run
    assign met = match && (cnt_q >= LAST);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (flush) begin
            cnt_q <= '0;
        end else if (pair_valid) begin
            if (!match) begin
                cnt_q <= '0;
            end else if (cnt_q < LAST) begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end
endmodule : rlsi_run_cnt
`default_nettype wire

/* dv/rlsi_media_model.sv */
// behavioural media receiver: symbol pairs, noise pulses, signal detect
`timescale 1ns/10ps
`default_nettype none
module rlsi_media_model (
    input wire logic ref_clk,
    output var rlsi_pkg::rlsi_pair_t pair_q,
    output var logic sd_q
);
    initial begin
        pair_q = '0;
        sd_q = 1'b0;
    end
    // idle cycles carry the inverted pattern so no stale pair looks valid
    task automatic send(input logic [9:0] p, input int n, input logic v,
                        input logic nz, input int gap);
        repeat (n) begin
            @(posedge ref_clk);
            pair_q <= '{v, p[9:5], p[4:0], nz};
            repeat (gap) begin
                @(posedge ref_clk);
                pair_q <= '{1'b0, ~p[9:5], ~p[4:0], 1'b0};
            end
        end
        @(posedge ref_clk);
        pair_q <= '{1'b0, ~p[9:5], ~p[4:0], 1'b0};
    endtask : send
    task automatic set_sd(input logic v);
        @(posedge ref_clk);
        sd_q <= v;
    endtask : set_sd
endmodule : rlsi_media_model
`default_nettype wire

/* dv/rlsi_top_sva.sv */
// assertion checker for the receive line state indicator ports
`timescale 1ns/10ps
`default_nettype none
module rlsi_top_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire rlsi_pkg::rlsi_bus_req_t bus_req,
    input wire logic [7:0] rd_data_q,
    input wire rlsi_pkg::rlsi_pair_t pair_in,
    input wire logic signal_present_input,
    input wire logic [3:0] line_state_q,
    input wire logic history_a_summary_q,
    input wire logic irq_q
);
    logic [7:0] ctl_q;
    logic [7:0] en_q;
    logic [3:0] sd_q;
    wire logic sd = signal_present_input;
    wire logic [9:0] pat = {pair_in.first, pair_in.second};
    // trust the link once detect is steady past the synchroniser or loopback is on, never in stop mode
    wire logic ok = (sd && sd_q == 4'hf || ctl_q[0]) && !ctl_q[1];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            en_q <= 8'h00;
            sd_q <= 4'h0;
        end else begin
            if (bus_req.wr && bus_req.addr == 8'h00) ctl_q <= bus_req.wdata;
            if (bus_req.wr && bus_req.addr == 8'h02) en_q <= bus_req.wdata;
            sd_q <= sd ? sd_q + {3'h0, sd_q != 4'hf} : 4'h0;
        end
    end
    sequence s_run(c, p);
        (c && pair_in.valid && !pair_in.noise && pat == p)[*8];
    endsequence
    property p_rst_unknown;
        $rose(rst_n) |-> line_state_q == 4'h8;
    endproperty
    a_rst_unknown: assert property (p_rst_unknown)
        else $error("line state not unknown after reset");
    property p_rd_upper;
        bus_req.rd && bus_req.addr == 8'h08 |=> rd_data_q[7:4] == 4'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("state read shows upper bits");
    property p_no_signal;
        (!sd && !ctl_q[0])[*8] |-> line_state_q == 4'h2;
    endproperty
    a_no_signal: assert property (p_no_signal)
        else $error("no signal code missing");
    property p_loop_halt;
        s_run(ctl_q[0] && !ctl_q[1] && !sd, 10'h084)
            |-> ##[2:3] line_state_q == 4'h5;
    endproperty
    a_loop_halt: assert property (p_loop_halt)
        else $error("loopback halt run not seen");
    property p_quiet;
        s_run(ok, 10'h000) |-> ##[2:3] line_state_q == 4'h6;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("quiet run not seen");
    property p_active;
        ok && pair_in.valid && !pair_in.noise && pat == 10'h311
            |-> ##[2:3] line_state_q == 4'h0;
    endproperty
    a_active: assert property (p_active)
        else $error("start delimiter not seen");
    property p_noise;
        (ok && pair_in.noise && !pair_in.valid)[*8] ##1
            (ok && pair_in.noise && !pair_in.valid)[*8]
            |-> ##[2:3] line_state_q == 4'h7;
    endproperty
    a_noise: assert property (p_noise)
        else $error("noise state not seen");
    property p_wr_reject;
        bus_req.wr && bus_req.addr == 8'h08 && en_q[1] |-> ##[1:3] irq_q;
    endproperty
    a_wr_reject: assert property (p_wr_reject)
        else $error("state write not flagged");
endmodule : rlsi_top_chk
bind rlsi_top rlsi_top_chk u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data_q(rd_data_q), .pair_in(pair_in),
    .signal_present_input(signal_present_input),
    .line_state_q(line_state_q), .history_a_summary_q(history_a_summary_q),
    .irq_q(irq_q)
);
`default_nettype wire

/* dv/rlsi_bench.sv */
// self-checking bench for the receive line state indicator
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("wrong value at %0t got %h exp %h", $time, g, e); \
        end \
    end
module rlsi_bench;
    logic ref_clk;
    logic rst_n;
    rlsi_pkg::rlsi_bus_req_t req;
    rlsi_pkg::rlsi_pair_t pair;
    logic sd;
    logic [7:0] rd_data_q;
    logic [3:0] ls;
    logic summ;
    logic irq;
    int error_cnt = 0;
    int num_checks = 0;
    logic [9:0] pat [5] = '{10'h000, 10'h084, 10'h080, 10'h3ff, 10'h311};
    int thr [5] = '{8, 8, 8, 2, 1};
    logic [2:0] cod [5] = '{3'h6, 3'h5, 3'h4, 3'h1, 3'h0};
    rlsi_top dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req),
        .rd_data_q(rd_data_q), .pair_in(pair), .signal_present_input(sd),
        .line_state_q(ls), .history_a_summary_q(summ), .irq_q(irq)
    );
    rlsi_media_model u_media (.ref_clk(ref_clk), .pair_q(pair), .sd_q(sd));
    function automatic logic [7:0] hbit(input logic [2:0] c);
        case (c)
            3'h2: return 8'h01;
            3'h6: return 8'h02;
            3'h5: return 8'h04;
            3'h4: return 8'h08;
            3'h7: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction : hbit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req <= '{a, d, 1'b0, 1'b0};
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        `CHK(rd_data_q & m, e)
        @(posedge ref_clk);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // run needs well under a thousand cycles
    initial begin
        repeat (10000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        logic [7:0] h;
        logic [2:0] prev;
        int s;
        rst_n = 1'b0;
        req = '0;
        s = $urandom(15);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(8'h08, 8'h02);
        `CHK(ls, 4'h2)
        rd(8'h09, 8'h41);
        rd(8'h20, 8'h00);
        h = 8'($urandom);
        wr(8'h0b, h);
        rd(8'h0b, h);
        wr(8'h0b, 8'h00);
        wr(8'h02, 8'h02);
        wr(8'h08, 8'h55);
        rd(8'h08, 8'h02);
        `CHK(irq, 1'b1)
        wr(8'h03, 8'h02);
        rd(8'h01, 8'h00);
        `CHK(irq, 1'b0)
        u_media.set_sd(1'b1);
        repeat (8) @(posedge ref_clk);
        prev = 3'h2;
        h = 8'h41;
        // one pair short of each run must leave the state unknown
        for (int i = 0; i < 5; i++) begin
            if (thr[i] > 1) begin
                u_media.send(pat[i], thr[i] - 1, 1'b1, 1'b0, 0);
                if (prev > 3'h1) h |= 8'h80;
                rd(8'h08, {5'h01, prev});
                `CHK(ls, {1'b1, prev})
            end
            s = 1 + $urandom_range(0, 2);
            u_media.send(pat[i], s, 1'b1, 1'b0, $urandom_range(0, 1));
            rd(8'h08, {5'h00, cod[i]});
            `CHK(ls, {1'b0, cod[i]})
            h |= hbit(cod[i]);
            rd(8'h09, h);
            prev = cod[i];
        end
        u_media.send(10'h000, 8, 1'b1, 1'b0, 0);
        rd(8'h08, 8'h06);
        wr(8'h0b, 8'h02);
        wr(8'h02, 8'h01);
        rd(8'h01, 8'h01);
        `CHK(summ, 1'b1)
        `CHK(irq, 1'b1)
        wr(8'h09, 8'hff);
        rd(8'h09, 8'h00);
        rd(8'h01, 8'h00);
        `CHK(irq, 1'b0)
        u_media.send(10'h155, 16, 1'b0, 1'b1, 0);
        // the noise state lands one edge after the sixteenth pulse counts
        @(posedge ref_clk);
        rd(8'h08, 8'h07);
        rd(8'h09, 8'h50);
        u_media.set_sd(1'b0);
        wr(8'h00, 8'h01);
        u_media.send(10'h084, 8, 1'b1, 1'b0, 0);
        rd(8'h08, 8'h05);
        wr(8'h00, 8'h00);
        repeat (8) @(posedge ref_clk);
        rd(8'h08, 8'h02);
        u_media.set_sd(1'b1);
        wr(8'h00, 8'h02);
        rd(8'h08, 8'h02, 8'h07);
        u_media.send(10'h3ff, 2, 1'b1, 1'b0, 0);
        rd(8'h08, 8'h03, 8'h07);
        wr(8'h00, 8'h01);
        rd(8'h08, 8'h02, 8'h07);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(ls, 4'h8)
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h00, 8'h00);
        rd(8'h09, 8'h41);
        complete_run();
    end
endmodule : rlsi_bench
`default_nettype wire
